// ### hw/csa_pkg.sv
// Shared constants and types for the card slot register bank
package csa_pkg;
   localparam int SLOT_N = 3;
   localparam logic [7:0] ADDR_SLOT1 = 8'h01;
   localparam logic [7:0] ADDR_SLOT2 = 8'h02;
   localparam logic [7:0] ADDR_SLOT3 = 8'h03;
   localparam logic [7:0] ADDR_BANK_ALIAS = 8'h40;
   localparam logic [7:0] ADDR_SLOT_SEL = 8'h30;
   localparam logic [7:0] ADDR_REG_SEL = 8'h31;
   localparam logic [1:0] SEL_MISC = 2'h0;
   localparam logic [1:0] SEL_SHORT = 2'h1;
   localparam logic [1:0] SEL_LONG_HI = 2'h2;
   localparam logic [1:0] SEL_LONG_LO = 2'h3;
   localparam logic [7:0] SHORT_RST = 8'haa;
   localparam logic [7:0] LONG_HI_RST = 8'ha4;
   localparam logic [7:0] LONG_LO_RST = 8'h74;
   localparam logic [7:0] SLOT_SEL_RST = 8'h03;
   localparam logic [1:0] REG_SEL_RST = 2'h0;
   localparam int ST_ACTIVE = 7;
   localparam int ST_EARLY = 6;
   localparam int ST_MUTE = 5;
   localparam int ST_OVERLOAD_FAULT_FLAG = 4;
   localparam int ST_SUPERVISOR_FAULT_FLAG = 3;
   localparam int ST_CLOCK_SWITCHED_FLAG = 2;
   localparam int ST_RSVD = 1;
   localparam int ST_CARD_PRESENT_FLAG = 0;
   localparam int CT_LOW = 7;
   localparam int CT_IOEN = 6;
   localparam int CT_REG_HI = 5;
   localparam int CT_REG_LO = 4;
   localparam int CT_CLOCK_POWERDOWN_SELECT = 3;
   localparam int CT_HIGH = 2;
   localparam int CT_WARM = 1;
   localparam int CT_START = 0;

   typedef enum logic [1:0] {CSA_VCC_3V, CSA_VCC_5V, CSA_VCC_1V8} csa_vcc_t;

   typedef struct packed {
      logic active;
      logic early;
      logic mute;
      logic overload;
      logic clk_sw;
   } csa_slot_evt_t;

   // Field order matches the control byte, bit 7 first
   typedef struct packed {
      logic low_supply_select;
      logic io_line_enable;
      logic [1:0] reg_select;
      logic clock_powerdown_select;
      logic high_supply_select;
      logic warm;
      logic start;
   } csa_slot_ctl_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } csa_bus_req_t;
endpackage

// ### hw/csa_slot.sv
// Status flags and control bits of one card slot
`timescale 1ns/10ps
module csa_slot
   import csa_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire csa_slot_evt_t evt,
   input wire logic supervisor_fault,
   input wire logic presence_pin_level,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] wdata,
   output logic [7:0] status,
   output csa_slot_ctl_t ctl,
   output csa_vcc_t supply,
   output logic irq_req
);
   logic early;
   logic mute;
   logic overload_fault_flag;
   logic supervisor_fault_flag;
   logic start_prev;
   logic start_ok;

   // ******************************
   // Sticky flags, set wins over read clear
   // ******************************
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         early <= 1'b0;
         mute <= 1'b0;
         overload_fault_flag <= 1'b0;
      end
      else
      begin
         early <= evt.early | (early & ~rd_en);
         mute <= evt.mute | (mute & ~rd_en);
         overload_fault_flag <= evt.overload |
            (overload_fault_flag & ~rd_en);
      end
   end

   // Set from reset until the first status read
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         supervisor_fault_flag <= 1'b1;
      else
         supervisor_fault_flag <= supervisor_fault |
            (supervisor_fault_flag & ~rd_en);
   end

   assign status = {evt.active, early, mute, overload_fault_flag,
      supervisor_fault_flag, evt.clk_sw, 1'b0,
      presence_pin_level};
   assign irq_req = early | mute | overload_fault_flag |
      supervisor_fault_flag;
   assign start_ok = ~supervisor_fault_flag & ~overload_fault_flag &
      presence_pin_level;

   // ******************************
   // Control bits
   // ******************************
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         ctl <= '0;
      else if (wr_en)
      begin
         ctl.io_line_enable <= wdata[CT_IOEN];
         ctl.reg_select <= wdata[CT_REG_HI:CT_REG_LO];
         ctl.clock_powerdown_select <= wdata[CT_CLOCK_POWERDOWN_SELECT];
         ctl.warm <= wdata[CT_WARM];
         ctl.start <= wdata[CT_START] & start_ok;
         if (!ctl.start)
         begin
            ctl.low_supply_select <= wdata[CT_LOW];
            ctl.high_supply_select <= wdata[CT_HIGH];
         end
      end
      else if ((ctl.start & ~start_prev) | evt.mute)
         ctl.warm <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         start_prev <= 1'b0;
      else
         start_prev <= ctl.start;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         supply <= CSA_VCC_3V;
      else if (ctl.low_supply_select)
         supply <= CSA_VCC_1V8;
      else if (ctl.high_supply_select)
         supply <= CSA_VCC_5V;
      else
         supply <= CSA_VCC_3V;
   end

   // ******************************
   // Checks
   // ******************************
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_flag_read_clear: assert property (
      rd_en && !evt.mute && !evt.early |=> !mute && !early)
      else $error("flag not cleared by read");
   chk_supervisor_fault_flag_set: assert property (
      supervisor_fault |=> supervisor_fault_flag ##1
      (supervisor_fault_flag || $past(rd_en)))
      else $error("supervisor flag missed");
   chk_start_gate: assert property (
      wr_en && (supervisor_fault_flag || !presence_pin_level) |=>
      !ctl.start)
      else $error("start accepted while blocked");
   chk_supply_hold: assert property (
      ctl.start && wr_en |=> $stable(ctl.low_supply_select) &&
      $stable(ctl.high_supply_select))
      else $error("supply bits changed while started");
   chk_warm_clear: assert property (
      ctl.warm && !wr_en && evt.mute |=> !ctl.warm)
      else $error("warm not cleared on mute");
   cov_start: cover property (wr_en && wdata[CT_START] ##1 ctl.start);
endmodule

// ### hw/csa_regs.sv
// Register bank: shared ATR counters and slot 3 to 5 status/control
`timescale 1ns/10ps
// ******************************
// Behaviour
// - At slot 1/2 addresses select 01 short, 10 long high, 11 long low
// - Shared 8-bit ATR counter, read/write, resets to aah
// - Shared long counter upper byte, read/write, resets to a4h
// - Shared long counter lower byte, read/write, resets to 74h
// - Slots 3-5 read status, write supply, io, select, clock, warm, start
// - Slots 3-5 register also reachable at bank address 40h
// - Status bit 7 shows card active
// - Status bit 6 set when card answers too early
// - Status bit 5 set when card stays mute
// - Status bit 4 set on overload or overheating
// - Status bit 3 set on supervisor fault
// - Early, mute, overload and supervisor flags clear on status read
// - Status bit 2 shows clock switched in power-down
// - Status bit 0 is live presence pin, bit 1 reserved zero
// - Interrupt low while any sticky flag set, released after read
// - Supervisor flag set after reset; interrupt low while supervisor active
// - Start 1 activates only with no faults and card present
// - Warm bit starts warm reset, cleared on start or mute
// - Supply select 1.8 V, else 5 V or 3 V; frozen while started
// ******************************
module csa_regs
   import csa_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire csa_bus_req_t bus_req,
   output logic [7:0] reg_rdata,
   input wire csa_slot_evt_t [SLOT_N-1:0] slot_evt,
   input wire logic supervisor_fault_pin,
   input wire logic [SLOT_N-1:0] presence_pin,
   output csa_slot_ctl_t [SLOT_N-1:0] slot_ctl,
   output csa_vcc_t [SLOT_N-1:0] slot_supply,
   output logic [7:0] atr_short_counter,
   output logic [7:0] atr_long_counter_high,
   output logic [7:0] atr_long_counter_low,
   output logic interrupt_out_n
);
   logic [SLOT_N:0] pin_meta;
   logic [SLOT_N:0] pin_sync;
   logic supervisor_fault;
   logic [SLOT_N-1:0] presence_pin_level;
   logic [7:0] slot_sel;
   logic [1:0] reg_sel;
   logic is_slot12;
   logic [SLOT_N-1:0] slot_hit;
   logic [SLOT_N-1:0][7:0] slot_status;
   logic [SLOT_N-1:0] irq_req;
   logic [7:0] next_rdata;
   logic cnt_wr;

   // ******************************
   // Pin synchronisers
   // ******************************
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pin_meta <= '0;
         pin_sync <= '0;
      end
      else
      begin
         pin_meta <= {supervisor_fault_pin, presence_pin};
         pin_sync <= pin_meta;
      end
   end

   assign supervisor_fault = pin_sync[SLOT_N];
   assign presence_pin_level = pin_sync[SLOT_N-1:0];

   // ******************************
   // Address decode
   // ******************************
   assign is_slot12 = (bus_req.addr == ADDR_SLOT1) ||
      (bus_req.addr == ADDR_SLOT2);
   assign cnt_wr = bus_req.wr && is_slot12;

   always_comb
   begin
      for (int i = 0; i < SLOT_N; i++)
      begin
         slot_hit[i] = (bus_req.addr == ADDR_SLOT3 + 8'(i)) ||
            ((bus_req.addr == ADDR_BANK_ALIAS) &&
            (slot_sel == ADDR_SLOT3 + 8'(i)));
      end
   end

   // ******************************
   // Selector registers
   // ******************************
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         slot_sel <= SLOT_SEL_RST;
      else if (bus_req.wr && bus_req.addr == ADDR_SLOT_SEL &&
         bus_req.wdata >= ADDR_SLOT3 &&
         bus_req.wdata < ADDR_SLOT3 + 8'(SLOT_N))
         slot_sel <= bus_req.wdata;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         reg_sel <= REG_SEL_RST;
      else if (bus_req.wr && bus_req.addr == ADDR_REG_SEL)
         reg_sel <= bus_req.wdata[1:0];
   end

   // ******************************
   // Shared ATR counters
   // ******************************
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         atr_short_counter <= SHORT_RST;
      else if (cnt_wr && reg_sel == SEL_SHORT)
         atr_short_counter <= bus_req.wdata;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         atr_long_counter_high <= LONG_HI_RST;
      else if (cnt_wr && reg_sel == SEL_LONG_HI)
         atr_long_counter_high <= bus_req.wdata;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         atr_long_counter_low <= LONG_LO_RST;
      else if (cnt_wr && reg_sel == SEL_LONG_LO)
         atr_long_counter_low <= bus_req.wdata;
   end

   // ******************************
   // Card slots 3 to 5
   // ******************************
   for (genvar g = 0; g < SLOT_N; g++)
   begin : g_slot
      csa_slot u_slot (
         .clk(clk),
         .sys_rst(sys_rst),
         .evt(slot_evt[g]),
         .supervisor_fault(supervisor_fault),
         .presence_pin_level(presence_pin_level[g]),
         .wr_en(bus_req.wr && slot_hit[g]),
         .rd_en(bus_req.rd && slot_hit[g]),
         .wdata(bus_req.wdata),
         .status(slot_status[g]),
         .ctl(slot_ctl[g]),
         .supply(slot_supply[g]),
         .irq_req(irq_req[g])
      );
   end

   // ******************************
   // Read data
   // ******************************
   always_comb
   begin
      next_rdata = 8'h00;
      if (is_slot12)
      begin
         case (reg_sel)
            SEL_SHORT: next_rdata = atr_short_counter;
            SEL_LONG_HI: next_rdata = atr_long_counter_high;
            SEL_LONG_LO: next_rdata = atr_long_counter_low;
            default: next_rdata = 8'h00;
         endcase
      end
      else if (bus_req.addr == ADDR_SLOT_SEL)
         next_rdata = slot_sel;
      else if (bus_req.addr == ADDR_REG_SEL)
         next_rdata = {6'h00, reg_sel};
      for (int i = 0; i < SLOT_N; i++)
      begin
         if (slot_hit[i])
            next_rdata = slot_status[i];
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         reg_rdata <= 8'h00;
      else if (bus_req.rd)
         reg_rdata <= next_rdata;
      else
         reg_rdata <= 8'h00;
   end

   // ******************************
   // Interrupt output
   // ******************************
   // Low while any flag is pending or the supervisor still holds
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         interrupt_out_n <= 1'b0;
      else
         interrupt_out_n <= ~(|irq_req | supervisor_fault);
   end

   // ******************************
   // Checks
   // ******************************
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   chk_reset_values: assert property (
      $fell(sys_rst) |-> atr_short_counter == SHORT_RST &&
      atr_long_counter_high == LONG_HI_RST &&
      atr_long_counter_low == LONG_LO_RST)
      else $error("counter reset value wrong");

   chk_sel_read: assert property (
      bus_req.rd && bus_req.addr == ADDR_SLOT2 && reg_sel == SEL_LONG_LO
      |=> reg_rdata == $past(atr_long_counter_low))
      else $error("select did not reach lower byte");

   chk_sel_write: assert property (
      bus_req.wr && bus_req.addr == ADDR_SLOT1 && reg_sel == SEL_SHORT
      |=> atr_short_counter == $past(bus_req.wdata) &&
      $stable(atr_long_counter_high))
      else $error("short counter write lost");

   chk_alias_read: assert property (
      bus_req.rd && bus_req.addr == ADDR_BANK_ALIAS &&
      slot_sel == ADDR_SLOT3 |=> reg_rdata == $past(slot_status[0]))
      else $error("alias read wrong slot");

   chk_status_live: assert property (
      bus_req.rd && bus_req.addr == ADDR_SLOT3 |=>
      reg_rdata[ST_ACTIVE] == $past(slot_evt[0].active) &&
      reg_rdata[ST_CLOCK_SWITCHED_FLAG] == $past(slot_evt[0].clk_sw) &&
      reg_rdata[ST_CARD_PRESENT_FLAG] == $past(presence_pin_level[0]) &&
      !reg_rdata[ST_RSVD])
      else $error("status live bits wrong");

   chk_early_seen: assert property (
      slot_evt[1].early ##1 (bus_req.rd && bus_req.addr == ADDR_SLOT3 + 8'h01)
      |=> reg_rdata[ST_EARLY])
      else $error("early answer not reported");

   chk_irq_low: assert property (
      |irq_req |=> !interrupt_out_n)
      else $error("interrupt not asserted");

   chk_irq_release: assert property (
      !(|irq_req) && !supervisor_fault |=> interrupt_out_n)
      else $error("interrupt not released");

   chk_ctl_write: assert property (
      bus_req.wr && bus_req.addr == ADDR_SLOT3 |=>
      slot_ctl[0].io_line_enable == $past(bus_req.wdata[CT_IOEN]) &&
      $stable(slot_status[0][ST_EARLY]))
      else $error("control write mishandled");

   chk_rdata_idle: assert property (
      !bus_req.rd |=> reg_rdata == 8'h00)
      else $error("read data not idle");

   chk_short_read: assert property (
      bus_req.rd && is_slot12 && reg_sel == SEL_SHORT |=>
      reg_rdata == $past(atr_short_counter))
      else $error("short counter read wrong");

   chk_hi_read: assert property (
      bus_req.rd && is_slot12 && reg_sel == SEL_LONG_HI |=>
      reg_rdata == $past(atr_long_counter_high))
      else $error("long high read wrong");

   chk_misc_read: assert property (
      bus_req.rd && is_slot12 && reg_sel == SEL_MISC |=>
      reg_rdata == 8'h00)
      else $error("unselected counter read not zero");

   chk_hi_write: assert property (
      cnt_wr && reg_sel == SEL_LONG_HI |=>
      atr_long_counter_high == $past(bus_req.wdata) &&
      $stable(atr_long_counter_low))
      else $error("long high write lost");

   chk_lo_write: assert property (
      cnt_wr && reg_sel == SEL_LONG_LO |=>
      atr_long_counter_low == $past(bus_req.wdata) &&
      $stable(atr_long_counter_high))
      else $error("long low write lost");

   chk_cnt_hold: assert property (
      !cnt_wr |=> $stable(atr_short_counter) &&
      $stable(atr_long_counter_high) && $stable(atr_long_counter_low))
      else $error("counter changed without write");

   chk_reg_sel_wr: assert property (
      bus_req.wr && bus_req.addr == ADDR_REG_SEL |=>
      reg_sel == $past(bus_req.wdata[1:0]))
      else $error("register select write lost");

   chk_slot_sel_range: assert property (
      slot_sel >= ADDR_SLOT3 && slot_sel < ADDR_SLOT3 + 8'(SLOT_N))
      else $error("slot select out of range");

   chk_alias_one: assert property (
      $onehot0(slot_hit))
      else $error("alias reached several slots");

   chk_alias_write: assert property (
      bus_req.wr && bus_req.addr == ADDR_BANK_ALIAS &&
      slot_sel == ADDR_SLOT3 + 8'h01 |=>
      slot_ctl[1].io_line_enable == $past(bus_req.wdata[CT_IOEN]))
      else $error("alias write missed slot");

   chk_rsvd_zero: assert property (
      bus_req.rd && |slot_hit |=> !reg_rdata[ST_RSVD])
      else $error("reserved status bit set");

   chk_sync_set: assert property (
      supervisor_fault_pin |-> ##2 supervisor_fault)
      else $error("supervisor sync lost high");

   chk_sync_clear: assert property (
      !supervisor_fault_pin |-> ##2 !supervisor_fault)
      else $error("supervisor sync lost low");

   chk_irq_supervisor_fault_flag: assert property (
      supervisor_fault |=> !interrupt_out_n)
      else $error("interrupt released under fault");

   cov_alias_write: cover property (
      bus_req.wr && bus_req.addr == ADDR_BANK_ALIAS);
   cov_irq_cycle: cover property (
      !interrupt_out_n ##1 bus_req.rd ##2 interrupt_out_n);
   cov_long_hi: cover property (
      cnt_wr && reg_sel == SEL_LONG_HI);
   cov_mute: cover property (slot_evt[2].mute);
endmodule

// ### bench/csa_host.sv
// Host model: register bus master for the card slot register bank
`timescale 1ns/10ps
module csa_host
   import csa_pkg::*;
(
   input wire logic clk,
   input wire logic [7:0] reg_rdata,
   output csa_bus_req_t bus_req
);
   initial bus_req = '0;

   // One write strobe cycle; the request stays until the next one or idle
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge clk);
      #1;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      #1;
      v = reg_rdata;
   endtask

   // Drops both strobes before the bench lets clock edges pass
   task automatic idle;
      bus_req <= '0;
   endtask
endmodule

// ### bench/csa_regs_tb.sv
// Self-checking bench for the card slot register bank
`timescale 1ns/10ps
module csa_regs_tb
   import csa_pkg::*;
();
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   csa_bus_req_t bus_req;
   logic [7:0] reg_rdata;
   csa_slot_evt_t [SLOT_N-1:0] slot_evt = '0;
   logic supervisor_fault_pin = 1'b0;
   logic [SLOT_N-1:0] presence_pin = 3'b101;
   csa_slot_ctl_t [SLOT_N-1:0] slot_ctl;
   csa_vcc_t [SLOT_N-1:0] slot_supply;
   logic [7:0] atr_short_counter;
   logic [7:0] atr_long_counter_high;
   logic [7:0] atr_long_counter_low;
   logic interrupt_out_n;
   int n_mismatch = 0;
   int n_tests = 0;
   logic [7:0] d;
   logic [7:0] flg [SLOT_N] = '{8'h08, 8'h08, 8'h08};
   logic [7:0] cur [SLOT_N] = '{8'h00, 8'h00, 8'h00};
   logic [7:0] cnt [3] = '{SHORT_RST, LONG_HI_RST, LONG_LO_RST};

   always #4 clk = ~clk;

   csa_host i_host (.clk(clk), .reg_rdata(reg_rdata), .bus_req(bus_req));

   csa_regs i_dut (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req),
      .reg_rdata(reg_rdata), .slot_evt(slot_evt),
      .supervisor_fault_pin(supervisor_fault_pin),
      .presence_pin(presence_pin), .slot_ctl(slot_ctl),
      .slot_supply(slot_supply), .atr_short_counter(atr_short_counter),
      .atr_long_counter_high(atr_long_counter_high),
      .atr_long_counter_low(atr_long_counter_low),
      .interrupt_out_n(interrupt_out_n));

   // ****************************************
   // Compare and model helpers
   // ****************************************
   task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t read %h expected %h", $time, g, e);
      end
   endtask

   task automatic cmp_pin(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t port %h expected %h", $time, g, e);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic tick(input int n);
      i_host.idle();
      repeat (n) @(posedge clk);
      #1;
   endtask

   function automatic logic [7:0] est(input int i);
      return flg[i] | {slot_evt[i].active, 4'h0, slot_evt[i].clk_sw, 1'b0,
         presence_pin[i]};
   endfunction

   // Status read; sticky flags drop unless the supervisor holds on
   task automatic rs(input int i);
      i_host.rd(ADDR_SLOT3 + 8'(i), d);
      cmp_reg(d, est(i));
      flg[i] = supervisor_fault_pin ? 8'h08 : 8'h00;
   endtask

   task automatic cirq;
      logic pend;
      pend = (flg[0] | flg[1] | flg[2]) != 0 || supervisor_fault_pin;
      cmp_pin(8'(interrupt_out_n), 8'(!pend));
   endtask

   // Supply bits frozen while started; start refused on fault or absence
   task automatic wc(input int i, input logic [7:0] v);
      logic [7:0] n;
      n = v;
      if (cur[i][0])
         n = {cur[i][7], v[6:3], cur[i][2], v[1:0]};
      if (n[0] && (flg[i][4:3] != 0 || !presence_pin[i]))
         n[0] = 1'b0;
      i_host.wr(ADDR_SLOT3 + 8'(i), v);
      cur[i] = n;
   endtask

   task automatic cc(input int i);
      cmp_pin(slot_ctl[i], cur[i]);
      cmp_pin(8'(slot_supply[i]), 8'(cur[i][7] ? CSA_VCC_1V8 :
         (cur[i][2] ? CSA_VCC_5V : CSA_VCC_3V)));
   endtask

   task automatic ccnt;
      cmp_pin(atr_short_counter, cnt[0]);
      cmp_pin(atr_long_counter_high, cnt[1]);
      cmp_pin(atr_long_counter_low, cnt[2]);
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      report_and_stop();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      void'($urandom(32'h3b41b829));
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      tick(1);
      cirq();
      ccnt();
      for (int s = 1; s < 4; s++)
      begin
         i_host.wr(ADDR_REG_SEL, 8'(s));
         i_host.rd(ADDR_SLOT1, d);
         cmp_reg(d, cnt[s-1]);
         cnt[s-1] = 8'($urandom);
         i_host.wr(ADDR_SLOT2, cnt[s-1]);
         i_host.rd(ADDR_SLOT1, d);
         cmp_reg(d, cnt[s-1]);
      end
      i_host.wr(ADDR_REG_SEL, 8'h00);
      i_host.wr(ADDR_SLOT1, 8'h55);
      i_host.rd(ADDR_SLOT2, d);
      cmp_reg(d, 8'h00);
      i_host.wr(8'h7f, 8'h5a);
      i_host.rd(8'h7f, d);
      cmp_reg(d, 8'h00);
      ccnt();
      rs(0);
      rs(1);
      tick(1);
      cirq();
      rs(2);
      tick(1);
      cirq();
      slot_evt[0].active <= 1'b1;
      slot_evt[1].clk_sw <= 1'b1;
      presence_pin[2] <= 1'b0;
      tick(3);
      for (int i = 0; i < SLOT_N; i++)
         rs(i);
      slot_evt[1].clk_sw <= 1'b0;
      tick(1);
      rs(1);
      for (int b = 0; b < 3; b++)
      begin
         slot_evt[b][3-b] <= 1'b1;
         tick(1);
         slot_evt[b][3-b] <= 1'b0;
         flg[b] = flg[b] | (8'h40 >> b);
         tick(2);
         cirq();
         rs(b);
         tick(1);
         cirq();
      end
      supervisor_fault_pin <= 1'b1;
      tick(4);
      flg = '{8'h08, 8'h08, 8'h08};
      cirq();
      rs(0);
      supervisor_fault_pin <= 1'b0;
      tick(3);
      for (int i = 0; i < SLOT_N; i++)
         rs(i);
      tick(1);
      cirq();
      wc(0, 8'h84);
      tick(1);
      cc(0);
      wc(0, 8'h04);
      tick(1);
      cc(0);
      wc(0, 8'h00);
      tick(1);
      cc(0);
      // Only this slot has its io line enabled
      wc(0, 8'h45);
      tick(1);
      cc(0);
      wc(0, 8'h81);
      tick(1);
      cc(0);
      rs(0);
      wc(0, 8'h04);
      tick(1);
      cc(0);
      wc(0, 8'h03);
      tick(1);
      cur[0][1] = 1'b0;
      cc(0);
      wc(1, 8'h39);
      tick(1);
      cc(1);
      wc(2, 8'h06);
      tick(1);
      cc(2);
      slot_evt[2].mute <= 1'b1;
      tick(1);
      slot_evt[2].mute <= 1'b0;
      cur[2][1] = 1'b0;
      flg[2] = flg[2] | 8'h20;
      tick(1);
      cc(2);
      rs(2);
      i_host.rd(ADDR_BANK_ALIAS, d);
      cmp_reg(d, est(0));
      i_host.wr(ADDR_SLOT_SEL, 8'h04);
      i_host.wr(ADDR_BANK_ALIAS, 8'h84);
      cur[1] = 8'h84;
      tick(1);
      cc(1);
      i_host.rd(ADDR_BANK_ALIAS, d);
      cmp_reg(d, est(1));
      tick(1);
      cmp_pin(reg_rdata, 8'h00);
      i_host.wr(ADDR_SLOT_SEL, 8'h07);
      i_host.rd(ADDR_SLOT_SEL, d);
      cmp_reg(d, 8'h04);
      report_and_stop();
   end
endmodule
